// ==== seems_pkg.sv ====
/*
 * Shared constants and types for the serial word memory sequencer pair.
 * Assumes a 200 MHz host clock and a separate link clock at the device.
 */
package seems_pkg;
    // ------------------------------------------------------------
    // Command codes and frame positions
    // ------------------------------------------------------------
    localparam logic [7:0] SEEMS_CMD_STATUS = 8'ha9;
    localparam logic [7:0] SEEMS_CMD_READ   = 8'h01;
    localparam logic [7:0] SEEMS_CMD_WRITE  = 8'h02;
    localparam logic [7:0] SEEMS_CMD_WEN    = 8'h03;
    localparam logic [7:0] write_block_cmd  = 8'h04;
    localparam logic [1:0] SEEMS_SEL_BUSY   = 2'h3;
    localparam logic [1:0] SEEMS_SEL_WEN    = 2'h2;
    localparam logic [1:0] SEEMS_SEL_ECC    = 2'h1;
    localparam int         SEEMS_STAT_EDGE  = 16;
    localparam int         SEEMS_WRITE_EDGE = 32;
    localparam int         SEEMS_DEPTH      = 64;
    // ------------------------------------------------------------
    // Times and derived counts
    // ------------------------------------------------------------
    localparam int SEEMS_CLK_MHZ                 = 200;
    localparam int SEEMS_LINK_NS                 = 12;
    localparam int self_timed_write_time_ms      = 15;
    localparam int status_lockout_time_us        = 12;
    localparam int byte_gap_clock_high_time_us   = 4;
    localparam int select_high_width_us          = 4;
    localparam int SEEMS_HOLD_AFTER_WRITE_US     = 4;
    // Write timer on the link clock, longest time rounds down
    localparam int SEEMS_WRITE_CYC = (self_timed_write_time_ms * 1000000) / SEEMS_LINK_NS;
    localparam int SEEMS_LOCK_CYC  = (status_lockout_time_us * 1000) / SEEMS_LINK_NS;
    // Host-side least times round up
    localparam int SEEMS_GAP_CYC   = byte_gap_clock_high_time_us * SEEMS_CLK_MHZ;
    localparam int SEEMS_CSH_CYC   = select_high_width_us * SEEMS_CLK_MHZ;
    localparam int SEEMS_HW_CYC    = SEEMS_HOLD_AFTER_WRITE_US * SEEMS_CLK_MHZ;
    localparam int SEEMS_STA_CYC   = status_lockout_time_us * SEEMS_CLK_MHZ;
    localparam int SEEMS_HALF_CYC  = 100;

    typedef enum logic [2:0] {
        SEEMS_DS_CMD   = 3'b000,
        SEEMS_DS_ADDR  = 3'b001,
        SEEMS_DS_DATA  = 3'b010,
        SEEMS_DS_STAT  = 3'b011,
        SEEMS_DS_IDLE  = 3'b100
    } seems_dstate_e;

    typedef enum logic [2:0] {
        SEEMS_HS_IDLE  = 3'b000,
        SEEMS_HS_LOW   = 3'b001,
        SEEMS_HS_HIGH  = 3'b010,
        SEEMS_HS_GAP   = 3'b011,
        SEEMS_HS_HOLD  = 3'b100,
        SEEMS_HS_DESEL = 3'b101
    } seems_hstate_e;
endpackage

// ==== seems_link_if.sv ====
/*
 * Serial link between host and device ends.
 * Assumes the bench resolves shared lines; all pins are plain logic.
 */
`timescale 1ns/1ps
interface seems_link_if;
    logic sck;          // Serial clock, idles high
    logic cs_n;         // Chip select, active low (also reset when tied)
    logic serial_input; // Host to device data
    logic data_out;     // Device to host data
    logic data_out_oe;  // Device drives data_out
    logic ready;        // 1 ready, 0 busy

    modport device (input sck, input cs_n, input serial_input,
                    output data_out, output data_out_oe, output ready);
    modport host   (output sck, output cs_n, output serial_input,
                    input data_out, input data_out_oe, input ready);
endinterface

// ==== seems_device.sv ====
/*
 * Device end: command sequencer, status output, self-timed write,
 * 64 x 16 storage.
 * Assumes link_clk runs free and far faster than sck; the serial pins
 * are oversampled on it through two flops, and it also paces the
 * write timer. srst is held for several link_clk cycles.
 */
`timescale 1ns/1ps

// Contract
// - Write finishes within 15 ms timer.
// - Status flag driven from 16th rising edge.
// - Status stays driven until select high.
// - Write starts at 32nd rising edge.
// - Select low during write: status only.
// - Host raises select after write first.
// - Host holds select 4 us after write.
// - Sequencer resets; status after 12 us.
// - Select high before next status mode.
// - Tied select/reset held low during write.
// - Tied mode: clock high outside status.
// - Output driven in status until select high.
// - Shared output: dummy bit after lockout.
// - Dummy byte must not equal status code.
// - Clock high hold every 8th clock.
// - Select high at least 4 us.
// - Busy flag 1 ready, 0 busy.
// - Write only when enable flag 0.
// - Enable flag changed only by commands.
// - Correction flag shows last read.
module seems_device (
    input  wire logic link_clk,
    input  wire logic srst,
    seems_link_if.device link
);
    import seems_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state but the storage in one word; a third sck flop gives the edge
    // detector its previous sample without touching the first flop
    typedef struct packed {
        logic [2:0]  s1;      // sck sync
        logic [2:0]  c1;      // cs sync
        logic [1:0]  d1;      // data sync
        seems_dstate_e st;
        logic [5:0]  bits;
        logic [7:0]  cmd;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [1:0]  sel;
        logic        wen_n;
        logic        ecc;
        logic        busy;
        logic [23:0] wtimer;
        logic [5:0]  waddr;
        logic [15:0] wdata;
        logic        dout;
        logic        oe;
        logic        done_seen;
    } seems_dev_s;

    seems_dev_s q, d;
    logic [15:0] mem_q [SEEMS_DEPTH];
    logic        we;
    logic        rise, fall, cs_hi;

    // Flag picked by the two status select bits
    function automatic logic flag_of(input logic [1:0] s, input seems_dev_s x);
        if (s == SEEMS_SEL_BUSY)
            flag_of = ~x.busy;
        else if (s == SEEMS_SEL_WEN)
            flag_of = x.wen_n;
        else
            flag_of = x.ecc;
    endfunction

    // ------------------------------------------------------------
    // Next state; link pins pass two flops before use
    // ------------------------------------------------------------
    always_comb begin
        d      = q;
        we     = 1'b0;
        d.s1   = {q.s1[1:0], link.sck};
        d.c1   = {q.c1[1:0], link.cs_n};
        d.d1   = {q.d1[0], link.serial_input};
        // Edges from flops two and three, never the first
        rise   = q.s1[1] & ~q.s1[2];
        fall   = ~q.s1[1] & q.s1[2];
        cs_hi  = q.c1[1];
        // Self-timed write, timer bounded by 15 ms count
        if (q.busy) begin
            if (q.wtimer == 24'(SEEMS_WRITE_CYC - 1)) begin
                d.busy = 1'b0;
                we     = 1'b1;
            end else begin
                d.wtimer = q.wtimer + 24'h1;
            end
        end
        if (cs_hi) begin
            // Select high aborts frame and releases output
            d.st   = SEEMS_DS_CMD;
            d.bits = 6'h0;
            d.oe   = 1'b0;
        end else if (rise) begin
            d.bits = q.bits + 6'h1;
            case (q.st)
                // Mode byte, MSB first
                SEEMS_DS_CMD: begin
                    d.cmd = {q.cmd[6:0], q.d1[1]};
                    if (q.bits == 6'd7) begin
                        d.st = SEEMS_DS_ADDR;
                        // During a write only the status code is honoured
                        if (q.busy && {q.cmd[6:0], q.d1[1]} != SEEMS_CMD_STATUS)
                            d.st = SEEMS_DS_IDLE;
                    end
                end
                // Address byte; status select sits in its top two bits
                SEEMS_DS_ADDR: begin
                    d.addr = {q.addr[6:0], q.d1[1]};
                    if (q.bits == 6'd15) begin
                        if (q.cmd == SEEMS_CMD_STATUS) begin
                            d.sel  = q.addr[6:5];
                            d.st   = SEEMS_DS_STAT;
                            d.oe   = 1'b1;
                            d.dout = flag_of(q.addr[6:5], q);
                        end else if (q.cmd == SEEMS_CMD_WEN) begin
                            d.wen_n = 1'b0;
                            d.st    = SEEMS_DS_IDLE;
                        end else if (q.cmd == write_block_cmd) begin
                            d.wen_n = 1'b1;
                            d.st    = SEEMS_DS_IDLE;
                        end else if (q.cmd == SEEMS_CMD_READ) begin
                            d.data = mem_q[{q.addr[4:0], q.d1[1]}];
                            d.ecc  = 1'b0;
                            d.oe   = 1'b1;
                            d.st   = SEEMS_DS_DATA;
                        end else begin
                            d.st   = SEEMS_DS_DATA;
                        end
                    end
                end
                // Data word; a write frame ends at its 32nd rising edge
                SEEMS_DS_DATA: begin
                    if (q.cmd != SEEMS_CMD_READ)
                        d.data = {q.data[14:0], q.d1[1]};
                    if (q.bits == 6'(SEEMS_WRITE_EDGE - 1)) begin
                        d.st = SEEMS_DS_IDLE;
                        if (q.cmd == SEEMS_CMD_WRITE && !q.wen_n && !q.busy) begin
                            d.busy   = 1'b1;
                            d.wtimer = 24'h0;
                            d.waddr  = q.addr[5:0];
                            d.wdata  = {q.data[14:0], q.d1[1]};
                            // Sequencer resets so a status frame may follow with select low
                            d.st     = SEEMS_DS_CMD;
                        end
                        d.bits = 6'h0;
                    end
                end
                // Status frame: further clocks are ignored
                SEEMS_DS_STAT: d.bits = q.bits;     // Hold, clock ignored
                default: begin
                    // Frame done or refused: wait for select high
                    d.st = SEEMS_DS_IDLE;
                end
            endcase
        end else if (fall) begin
            // Output updates after falling edge
            if (q.st == SEEMS_DS_DATA && q.cmd == SEEMS_CMD_READ) begin
                d.dout = q.data[15];
                d.data = {q.data[14:0], 1'b0};
            end else if (q.st == SEEMS_DS_STAT) begin
                d.dout = flag_of(q.sel, q);
            end
        end
        // Status output tracks the flag without clocks
        if (q.st == SEEMS_DS_STAT && !cs_hi)
            d.dout = flag_of(q.sel, q);
        // Reset with sck and select synchronisers at their idle high level
        if (srst) begin
            d = '0;
            d.st    = SEEMS_DS_CMD;
            d.wen_n = 1'b1;
            d.s1    = 3'h7;
            d.c1    = 3'h7;
        end
    end

    // ------------------------------------------------------------
    // Registers and storage
    // ------------------------------------------------------------
    // Storage has no reset: like the cells it models, its contents are
    // undefined until a write lands
    always_ff @(posedge link_clk) begin
        q <= d;
        if (we)
            mem_q[q.waddr] <= q.wdata;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pins come straight from flops, so no glitch reaches the host
    assign link.data_out    = q.dout;
    assign link.data_out_oe = q.oe;
    assign link.ready       = ~q.busy;
endmodule // seems_device

// ==== seems_host.sv ====
/*
 * Host end: runs one 16- or 32-clock frame per request with byte-gap holds
 * and select-high width. Makes sck by division of clk.
 */
`timescale 1ns/1ps
module seems_host (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_cmd,
    input  wire logic [7:0]  req_addr,
    input  wire logic [15:0] req_data,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    seems_link_if.host       link
);
    import seems_pkg::*;

    typedef struct packed {
        seems_hstate_e st;
        logic [31:0]   shreg;
        logic [15:0]   rx;
        logic [5:0]    nbit;
        logic [5:0]    total;
        logic [11:0]   tmr;
        logic          sck;
        logic          cs_n;
        logic          rsp;
        logic [1:0]    r1;
    } seems_host_s;

    seems_host_s q, d;

    function automatic logic [5:0] frame_len(input logic [7:0] c);
        frame_len = (c == SEEMS_CMD_WRITE || c == SEEMS_CMD_READ) ? 6'd32 : 6'd16;
    endfunction

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        d     = q;
        d.rsp = 1'b0;
        d.r1  = {q.r1[0], link.data_out};
        case (q.st)
            SEEMS_HS_IDLE: begin
                if (req_valid) begin
                    d.shreg = {req_cmd, req_addr, req_data};
                    d.total = frame_len(req_cmd);
                    d.nbit  = 6'h0;
                    d.cs_n  = 1'b0;
                    d.tmr   = 12'h0;
                    d.st    = SEEMS_HS_LOW;
                end
            end
            SEEMS_HS_LOW: begin
                d.tmr = q.tmr + 12'h1;
                if (q.tmr == 12'(SEEMS_HALF_CYC - 1)) begin
                    d.sck = 1'b0;
                    // Next bit goes out on the falling edge, half a period
                    // before the device samples it on the rising edge
                    if (q.nbit != 6'h0)
                        d.shreg = {q.shreg[30:0], 1'b0};
                    d.tmr = 12'h0;
                    d.st  = SEEMS_HS_HIGH;
                end
            end
            SEEMS_HS_HIGH: begin
                d.tmr = q.tmr + 12'h1;
                if (q.tmr == 12'(SEEMS_HALF_CYC - 1)) begin
                    d.sck   = 1'b1;
                    d.tmr   = 12'h0;
                    d.rx    = {q.rx[14:0], q.r1[1]};
                    d.nbit  = q.nbit + 6'h1;
                    if (q.nbit + 6'h1 == q.total)
                        d.st = SEEMS_HS_HOLD;
                    else if (q.nbit[2:0] == 3'h7)
                        d.st = SEEMS_HS_GAP;
                    else
                        d.st = SEEMS_HS_LOW;
                end
            end
            SEEMS_HS_GAP: begin
                d.tmr = q.tmr + 12'h1;
                if (q.tmr == 12'(SEEMS_GAP_CYC - 1)) begin
                    d.tmr = 12'h0;
                    d.st  = SEEMS_HS_LOW;
                end
            end
            SEEMS_HS_HOLD: begin
                d.tmr = q.tmr + 12'h1;
                if (q.tmr == 12'(SEEMS_HW_CYC - 1)) begin
                    d.cs_n = 1'b1;
                    d.rsp  = 1'b1;
                    // Status flag stands without clocks; take it late in the hold
                    if (q.total == 6'd16)
                        d.rx = {16{q.r1[1]}};
                    d.tmr  = 12'h0;
                    d.st   = SEEMS_HS_DESEL;
                end
            end
            default: begin
                d.tmr = q.tmr + 12'h1;
                if (q.tmr == 12'(SEEMS_CSH_CYC - 1))
                    d.st = SEEMS_HS_IDLE;
            end
        endcase
        if (srst) begin
            d      = '0;
            d.st   = SEEMS_HS_IDLE;
            d.sck  = 1'b1;
            d.cs_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign req_ready         = (q.st == SEEMS_HS_IDLE);
    assign rsp_valid         = q.rsp;
    assign rsp_data          = q.rx;
    assign link.sck          = q.sck;
    assign link.cs_n         = q.cs_n;
    assign link.serial_input = q.shreg[31];
endmodule // seems_host

// ==== seems_link_properties.sv ====
/*
 * Concurrent checks on the serial link between host and device ends.
 * Assumes the pins are watched on link_clk and srst is high at start.
 */
`timescale 1ns/1ps
module seems_link_properties
    import seems_pkg::*;
(
    input wire logic link_clk,
    input wire logic srst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic serial_input,
    input wire logic data_out,
    input wire logic data_out_oe,
    input wire logic ready
);
    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    logic        sck_q;
    logic [5:0]  edge_q;
    logic [7:0]  cmd_q;
    logic        en_q;
    logic [20:0] busy_q;

    // Counts sck rises per frame, keeps command byte and enable state
    always_ff @(posedge link_clk) begin
        if (srst) begin
            sck_q  <= 1'b1;
            edge_q <= 6'h00;
            cmd_q  <= 8'h00;
            en_q   <= 1'b0;
            busy_q <= 21'h000000;
        end else begin
            sck_q  <= sck;
            busy_q <= ready ? 21'h000000 : busy_q + 21'h000001;
            if (cs_n) begin
                edge_q <= 6'h00;
            end else if (sck && !sck_q) begin
                edge_q <= edge_q + 6'h01;
                if (edge_q < 6'h08) begin
                    cmd_q <= {cmd_q[6:0], serial_input};
                end
                // Busy device ignores enable changes
                if (edge_q == 6'h0f && ready && cmd_q == SEEMS_CMD_WEN) begin
                    en_q <= 1'b1;
                end
                if (edge_q == 6'h0f && ready && cmd_q == write_block_cmd) begin
                    en_q <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_status_at_16;
        $rose(data_out_oe) |-> !cs_n && edge_q == 6'h10;
    endproperty
    a_status_at_16: assert property (p_status_at_16)
        else $error("Output enabled away from the 16th clock");
    property p_hold_until_select;
        $fell(data_out_oe) |-> cs_n;
    endproperty
    a_hold_until_select: assert property (p_hold_until_select)
        else $error("Output released while still selected");
    property p_write_at_32;
        $fell(ready) |-> edge_q == 6'h20;
    endproperty
    a_write_at_32: assert property (p_write_at_32)
        else $error("Write began away from the 32nd clock");
    property p_write_needs_enable;
        $fell(ready) |-> en_q && cmd_q == SEEMS_CMD_WRITE;
    endproperty
    a_write_needs_enable: assert property (p_write_needs_enable)
        else $error("Write began without an enabled write command");
    property p_write_bounded;
        busy_q <= SEEMS_WRITE_CYC;
    endproperty
    a_write_bounded: assert property (p_write_bounded)
        else $error("Write ran past its longest time");
    property p_busy_status_only;
        $rose(data_out_oe) && !ready |-> cmd_q == SEEMS_CMD_STATUS;
    endproperty
    a_busy_status_only: assert property (p_busy_status_only)
        else $error("Non-status output while busy");
    property p_change_on_low;
        data_out_oe && $past(data_out_oe, 3) && $changed(data_out) |-> !sck;
    endproperty
    a_change_on_low: assert property (p_change_on_low)
        else $error("Output changed while sck high");
    property p_ready_after_reset;
        $fell(srst) |-> ready;
    endproperty
    a_ready_after_reset: assert property (p_ready_after_reset)
        else $error("Device busy after reset");
endmodule // seems_link_properties

// ==== tb_serial_eeprom_mode_sequencer.sv ====
/*
 * Bench joining host and device ends through the link interface.
 * Assumes each frame ends with rsp_valid and writes never finish in-run.
 */
`timescale 1ns/1ps
module tb_serial_eeprom_mode_sequencer;
    import seems_pkg::*;
    localparam int LIMIT = 95000;
    logic        clk;
    logic        link_clk;
    logic        srst;
    logic        req_valid;
    logic        req_ready;
    logic [7:0]  req_cmd;
    logic [7:0]  req_addr;
    logic [15:0] req_data;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    int          num_errors;
    int          n_compared;
    int          cyc;

    seems_link_if link ();
    seems_host u_seems_host (.clk(clk), .srst(srst), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link));
    seems_device u_seems_device (.link_clk(link_clk), .srst(srst), .link(link));
    seems_link_properties u_seems_link_properties (.link_clk(link_clk), .srst(srst),
        .sck(link.sck), .cs_n(link.cs_n), .serial_input(link.serial_input),
        .data_out(link.data_out), .data_out_oe(link.data_out_oe), .ready(link.ready));

    // ------------------------------------------------------------
    // Clocks and timeout
    // ------------------------------------------------------------
    // Host clock at 5 ns; link clock at 12 ns with an odd offset
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #6 link_clk = ~link_clk;
    end
    // Eleven frames need about 76k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One host request; entered and left just after a rising edge
    task automatic frame(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        req_cmd   <= c;
        req_addr  <= a;
        req_data  <= d;
        req_valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < LIMIT);
        @(posedge clk);
        req_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < LIMIT);
        @(posedge clk);
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    // A status flag fills all 16 data bits, so words are all ones or zeros
    initial begin
        srst       = 1'b1;
        req_valid  = 1'b0;
        req_cmd    = 8'h00;
        req_addr   = 8'h00;
        req_data   = 16'h0000;
        num_errors = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        frame(SEEMS_CMD_STATUS, {SEEMS_SEL_BUSY, 6'h00}, 16'h0000);
        check16(rsp_data, 16'hffff); // Ready flag after reset
        frame(SEEMS_CMD_STATUS, {SEEMS_SEL_ECC, 6'h00}, 16'h0000);
        check16(rsp_data, 16'h0000); // No correction seen
        frame(SEEMS_CMD_WRITE, 8'h05, 16'h1234);
        check1(link.ready, 1'b1); // Locked write leaves device idle
        frame(SEEMS_CMD_WEN, 8'h00, 16'h0000);
        frame(SEEMS_CMD_STATUS, {SEEMS_SEL_WEN, 6'h00}, 16'h0000);
        check16(rsp_data, 16'h0000); // Enable flag now clear
        frame(write_block_cmd, 8'h00, 16'h0000);
        frame(SEEMS_CMD_STATUS, {SEEMS_SEL_WEN, 6'h00}, 16'h0000);
        check16(rsp_data, 16'hffff); // Enable flag set again
        frame(SEEMS_CMD_WEN, 8'h00, 16'h0000);
        frame(SEEMS_CMD_WRITE, 8'h3f, 16'ha5c3);
        check1(link.ready, 1'b0); // Write in progress
        frame(SEEMS_CMD_STATUS, {SEEMS_SEL_BUSY, 6'h00}, 16'h0000);
        check16(rsp_data, 16'h0000); // Busy flag during write
        frame(SEEMS_CMD_READ, 8'h3f, 16'h0000);
        check16(rsp_data, 16'h0000); // Read refused while busy
        check1(link.ready, 1'b0); // Write still running
        end_of_test();
    end
endmodule // tb_serial_eeprom_mode_sequencer
